/* File: timer_clk_pkg.sv */
// Shared constants and state type for the timer clock select and prescaler block
package timer_clk_pkg;

    // Bus and datapath widths
    localparam int SFR_ADDR_W = 8;
    localparam int SFR_DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int NUM_TIMERS = 6;
    localparam int NUM_ARL = 4;

    // Timer clock control register: address and reset value
    localparam logic [SFR_ADDR_W-1:0] CLK_CTRL_ADDR = 8'h8e;
    localparam logic [SFR_DATA_W-1:0] CLK_CTRL_RESET = 8'h00;

    // Field positions inside the timer clock control register
    localparam int POS_PRESCALE_LSB = 0;
    localparam int POS_PRESCALE_MSB = 1;
    localparam int POS_T0_CLK_SEL = 2;
    localparam int POS_T1_CLK_SEL = 3;
    localparam int POS_T2_LO_SEL = 4;
    localparam int POS_T2_HI_SEL = 5;
    localparam int POS_T3_LO_SEL = 6;
    localparam int POS_T3_HI_SEL = 7;

    // Shared prescale select codes
    localparam logic [1:0] PRE_DIV12 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;
    localparam logic [1:0] PRE_DIV48 = 2'h2;
    localparam logic [1:0] PRE_EXT8 = 2'h3;

    // Divider terminal counts: 12 = mod-12 counter, 4 = low two bits, 48 = 12 x 4
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [1:0] DIV48_QUAD_LAST = 2'h3;
    localparam logic [2:0] EXT_DIV8_LAST = 3'h7;

    // Legacy timer modes
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_8RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // Count limits
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [CNT_W-1:0] WORD_MAX = 16'hffff;

    // Whole state of the block, registered in one process
    typedef struct packed {
        logic [SFR_DATA_W-1:0] ctrl;
        logic [SFR_DATA_W-1:0] rdata;
        logic [3:0] div_cnt;
        logic [1:0] div_quad;
        logic osc_s1;
        logic osc_s2;
        logic osc_prev;
        logic [2:0] osc_cnt;
        logic osc_tick;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic [1:0] pin_prev;
        logic [NUM_TIMERS-1:0][CNT_W-1:0] cnt;
        logic [NUM_TIMERS-1:0] ovf_lo;
        logic [NUM_TIMERS-1:0] ovf_hi;
    } state_t;

endpackage

/* File: timer_clock_select_prescaler.sv */
// Clock selection, shared prescaler and six counter/timers on one system clock
`timescale 1ns/1ps
module timer_clock_select_prescaler (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Special function register port
    input wire logic [timer_clk_pkg::SFR_ADDR_W-1:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [timer_clk_pkg::SFR_DATA_W-1:0] sfr_wdata,
    output logic [timer_clk_pkg::SFR_DATA_W-1:0] sfr_rdata,
    // External pins
    input wire logic timer_zero_count_input,
    input wire logic timer_one_count_input,
    input wire logic ext_osc_clk,
    // Legacy timer controls
    input wire logic timer_zero_counter_sel,
    input wire logic timer_one_counter_sel,
    input wire logic [1:0] timer_zero_mode,
    input wire logic [1:0] timer_one_mode,
    // Auto-reload timer controls
    input wire logic [timer_clk_pkg::NUM_ARL-1:0] split_mode,
    input wire logic timer_two_ext_clock_sel,
    input wire logic timer_three_ext_clock_sel,
    input wire logic timer_four_ext_clock_sel,
    input wire logic timer_five_ext_clock_sel,
    input wire logic [3:0] timer_four_five_byte_clock_sel,
    input wire logic [timer_clk_pkg::NUM_ARL-1:0][timer_clk_pkg::CNT_W-1:0] reload_value,
    // Run and load controls for all timers
    input wire logic [timer_clk_pkg::NUM_TIMERS-1:0] timer_run,
    input wire logic [timer_clk_pkg::NUM_TIMERS-1:0] timer_load,
    input wire logic [timer_clk_pkg::CNT_W-1:0] load_value,
    // Timer results
    output logic [timer_clk_pkg::NUM_TIMERS-1:0][timer_clk_pkg::CNT_W-1:0] count_value,
    output logic [timer_clk_pkg::NUM_TIMERS-1:0] overflow_low,
    output logic [timer_clk_pkg::NUM_TIMERS-1:0] overflow_high
);
    import timer_clk_pkg::*;

    state_t st_ff;
    state_t nxt_st;

    logic div4_tick;
    logic div12_tick;
    logic div48_tick;
    logic presc_tick;
    logic [1:0] pin_fall;
    logic [1:0] int_tick;
    logic [1:0] leg_tick;
    logic [1:0] leg_csel;
    logic [1:0][1:0] leg_mode;
    logic [NUM_ARL-1:0] arl_xsel;
    logic [NUM_ARL-1:0] arl_lo_msel;
    logic [NUM_ARL-1:0] arl_hi_msel;
    logic [NUM_ARL-1:0] arl_lo_tick;
    logic [NUM_ARL-1:0] arl_hi_tick;
    logic [1:0] t0_csel_bits;

    // Divider enables from one mod-12 counter and a quarter counter above it
    assign div4_tick = (st_ff.div_cnt[1:0] == DIV4_LAST);
    assign div12_tick = (st_ff.div_cnt == DIV12_LAST);
    assign div48_tick = div12_tick && (st_ff.div_quad == DIV48_QUAD_LAST);

    // Shared prescaler select
    always_comb begin
        case (st_ff.ctrl[POS_PRESCALE_MSB:POS_PRESCALE_LSB])
            PRE_DIV12: presc_tick = div12_tick;
            PRE_DIV4: presc_tick = div4_tick;
            PRE_DIV48: presc_tick = div48_tick;
            PRE_EXT8: presc_tick = st_ff.osc_tick;
            default: presc_tick = 1'b0;
        endcase
    end

    // Falling edges seen after the second synchroniser stage only
    assign pin_fall = st_ff.pin_prev & ~st_ff.pin_s2;

    // Legacy timer clock enables; the select bit is bypassed in counter mode
    assign t0_csel_bits = {st_ff.ctrl[POS_T1_CLK_SEL], st_ff.ctrl[POS_T0_CLK_SEL]};
    assign leg_csel = {timer_one_counter_sel, timer_zero_counter_sel};
    assign leg_mode = {timer_one_mode, timer_zero_mode};
    assign int_tick = t0_csel_bits | {presc_tick, presc_tick};
    assign leg_tick = (leg_csel & pin_fall) | (~leg_csel & int_tick);

    // Per auto-reload timer clock select vectors, timers 2 to 5 in order
    assign arl_xsel = {timer_five_ext_clock_sel, timer_four_ext_clock_sel,
                       timer_three_ext_clock_sel, timer_two_ext_clock_sel};
    assign arl_lo_msel = {timer_four_five_byte_clock_sel[2], timer_four_five_byte_clock_sel[0],
                          st_ff.ctrl[POS_T3_LO_SEL], st_ff.ctrl[POS_T2_LO_SEL]};
    assign arl_hi_msel = {timer_four_five_byte_clock_sel[3], timer_four_five_byte_clock_sel[1],
                          st_ff.ctrl[POS_T3_HI_SEL], st_ff.ctrl[POS_T2_HI_SEL]};

    // Low and high byte enables; the high byte only has its own clock when split
    for (genvar j = 0; j < NUM_ARL; j++) begin : g_arl_clk
        logic src_tick;
        assign src_tick = arl_xsel[j] ? st_ff.osc_tick : div12_tick;
        assign arl_lo_tick[j] = arl_lo_msel[j] | src_tick;
        assign arl_hi_tick[j] = split_mode[j] & (arl_hi_msel[j] | src_tick);
    end

    // Next-state logic for the whole block
    always_comb begin
        logic [13:0] sum13;
        logic [16:0] sum17;
        logic [8:0] sum8;
        sum13 = '0;
        sum17 = '0;
        sum8 = '0;
        nxt_st = st_ff;
        nxt_st.ovf_lo = '0;
        nxt_st.ovf_hi = '0;
        nxt_st.osc_tick = 1'b0;

        // Register decode; no page input, so the register answers on every page
        if (sfr_wr && (sfr_addr == CLK_CTRL_ADDR)) begin
            nxt_st.ctrl = sfr_wdata;
        end
        nxt_st.rdata = (sfr_rd && (sfr_addr == CLK_CTRL_ADDR)) ? st_ff.ctrl : '0;

        // Free-running mod-12 divider with quarter counter for divide by 48
        if (st_ff.div_cnt == DIV12_LAST) begin
            nxt_st.div_cnt = '0;
            nxt_st.div_quad = 2'(st_ff.div_quad + 2'h1);
        end else begin
            nxt_st.div_cnt = 4'(st_ff.div_cnt + 4'h1);
        end

        // External oscillator: synchronised, rising edges divided by eight
        nxt_st.osc_s1 = ext_osc_clk;
        nxt_st.osc_s2 = st_ff.osc_s1;
        nxt_st.osc_prev = st_ff.osc_s2;
        if (st_ff.osc_s2 && !st_ff.osc_prev) begin
            nxt_st.osc_cnt = 3'(st_ff.osc_cnt + 3'h1);
            nxt_st.osc_tick = (st_ff.osc_cnt == EXT_DIV8_LAST);
        end

        // Count inputs: two-flop synchroniser, then edge history; an input held
        // two clocks is always seen, which caps the event rate at a quarter clock
        nxt_st.pin_s1 = {timer_one_count_input, timer_zero_count_input};
        nxt_st.pin_s2 = st_ff.pin_s1;
        nxt_st.pin_prev = st_ff.pin_s2;

        // Legacy timers 0 and 1; a load wins over a count in the same cycle
        for (int k = 0; k < 2; k++) begin
            if (timer_load[k]) begin
                nxt_st.cnt[k] = load_value;
            end else if (timer_run[k] && leg_tick[k]) begin
                case (leg_mode[k])
                    MODE_13BIT: begin
                        sum13 = {1'b0, st_ff.cnt[k][15:8], st_ff.cnt[k][4:0]} + 14'h1;
                        nxt_st.cnt[k][4:0] = sum13[4:0];
                        nxt_st.cnt[k][15:8] = sum13[12:5];
                        nxt_st.ovf_hi[k] = sum13[13];
                    end
                    MODE_16BIT: begin
                        sum17 = {1'b0, st_ff.cnt[k]} + 17'h1;
                        nxt_st.cnt[k] = sum17[15:0];
                        nxt_st.ovf_hi[k] = sum17[16];
                    end
                    MODE_8RELOAD: begin
                        if (st_ff.cnt[k][7:0] == BYTE_MAX) begin
                            nxt_st.cnt[k][7:0] = st_ff.cnt[k][15:8];
                            nxt_st.ovf_hi[k] = 1'b1;
                        end else begin
                            nxt_st.cnt[k][7:0] = 8'(st_ff.cnt[k][7:0] + 8'h1);
                        end
                    end
                    MODE_SPLIT: begin
                        // Timer 1 simply holds in this mode
                        if (k == 0) begin
                            sum8 = {1'b0, st_ff.cnt[0][7:0]} + 9'h1;
                            nxt_st.cnt[0][7:0] = sum8[7:0];
                            nxt_st.ovf_lo[0] = sum8[8];
                        end
                    end
                    default: nxt_st.cnt[k] = st_ff.cnt[k];
                endcase
            end
        end

        // Split timer 0 high byte: internal clock only, started by timer 1's run bit
        if (!timer_load[0] && (timer_zero_mode == MODE_SPLIT) && timer_run[1] && int_tick[0]) begin
            sum8 = {1'b0, st_ff.cnt[0][15:8]} + 9'h1;
            nxt_st.cnt[0][15:8] = sum8[7:0];
            nxt_st.ovf_hi[0] = sum8[8];
        end

        // Auto-reload timers 2 to 5
        for (int j = 0; j < NUM_ARL; j++) begin
            if (timer_load[j+2]) begin
                nxt_st.cnt[j+2] = load_value;
            end else if (timer_run[j+2]) begin
                if (!split_mode[j]) begin
                    if (arl_lo_tick[j]) begin
                        if (st_ff.cnt[j+2] == WORD_MAX) begin
                            nxt_st.cnt[j+2] = reload_value[j];
                            nxt_st.ovf_hi[j+2] = 1'b1;
                        end else begin
                            nxt_st.cnt[j+2] = 16'(st_ff.cnt[j+2] + 16'h1);
                        end
                    end
                end else begin
                    if (arl_lo_tick[j]) begin
                        if (st_ff.cnt[j+2][7:0] == BYTE_MAX) begin
                            nxt_st.cnt[j+2][7:0] = reload_value[j][7:0];
                            nxt_st.ovf_lo[j+2] = 1'b1;
                        end else begin
                            nxt_st.cnt[j+2][7:0] = 8'(st_ff.cnt[j+2][7:0] + 8'h1);
                        end
                    end
                    if (arl_hi_tick[j]) begin
                        if (st_ff.cnt[j+2][15:8] == BYTE_MAX) begin
                            nxt_st.cnt[j+2][15:8] = reload_value[j][15:8];
                            nxt_st.ovf_hi[j+2] = 1'b1;
                        end else begin
                            nxt_st.cnt[j+2][15:8] = 8'(st_ff.cnt[j+2][15:8] + 8'h1);
                        end
                    end
                end
            end
        end
    end

    // State register; every field clears, control register to its reset value
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.ctrl <= CLK_CTRL_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign sfr_rdata = st_ff.rdata;
    assign count_value = st_ff.cnt;
    assign overflow_low = st_ff.ovf_lo;
    assign overflow_high = st_ff.ovf_hi;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_ctrl_readback: assert property (
        (sfr_rd && sfr_addr == CLK_CTRL_ADDR && !sfr_wr) |=> (sfr_rdata == $past(st_ff.ctrl)))
        else $error("control register read returned wrong value");

    a_div12_period: assert property (
        div12_tick |=> (!div12_tick)[*8] ##1 (!div12_tick)[*3] ##1 div12_tick)
        else $error("divide by 12 enable has wrong period");

    a_div4_period: assert property (
        div4_tick |=> (!div4_tick)[*3] ##1 div4_tick)
        else $error("divide by 4 enable has wrong period");

    a_div48_period: assert property (
        div48_tick |-> ##48 div48_tick)
        else $error("divide by 48 enable has wrong period");

    a_pin_fall_count: assert property (
        (timer_zero_counter_sel && timer_run[0] && timer_zero_mode == MODE_16BIT
         && !timer_load[0] && $fell(timer_zero_count_input))
        |-> ##3 (count_value[0] == $past(count_value[0], 3) + 16'h1))
        else $error("timer 0 did not count a falling input edge");

    a_system_clock_select: assert property (
        (!timer_zero_counter_sel && st_ff.ctrl[POS_T0_CLK_SEL] && timer_run[0]
         && timer_zero_mode == MODE_16BIT && !timer_load[0])
        |=> (count_value[0] == $past(count_value[0]) + 16'h1))
        else $error("timer 0 system clock select did not count every cycle");

    a_counter_ignores_sel: assert property (
        (timer_one_counter_sel && !pin_fall[1] && !timer_load[1])
        |=> $stable(count_value[1]))
        else $error("timer 1 counted without an input edge");

    a_arl_reload: assert property (
        (!split_mode[0] && timer_run[2] && !timer_load[2] && arl_lo_tick[0]
         && count_value[2] == WORD_MAX)
        |=> (count_value[2] == $past(reload_value[0]) && overflow_high[2]))
        else $error("timer 2 did not reload on overflow");

    a_hi_sel_unsplit: assert property (
        (!split_mode[0] && st_ff.ctrl[POS_T2_HI_SEL] && !arl_lo_tick[0] && !timer_load[2])
        |=> $stable(count_value[2]))
        else $error("timer 2 high byte select acted outside split mode");

    a_ext_div8_gap: assert property (
        st_ff.osc_tick |=> (!st_ff.osc_tick)[*8])
        else $error("external divide by 8 enable came too soon");

    c_pin_count: cover property (timer_zero_counter_sel && timer_run[0] && pin_fall[0]);
    c_split_high: cover property (split_mode[1] && timer_run[3] && overflow_high[3]);
    c_ext_prescale: cover property (st_ff.ctrl[1:0] == PRE_EXT8 && presc_tick);
    c_arl_reload: cover property (overflow_high[2] && !split_mode[0]);

endmodule

/* File: timer_clock_select_prescaler_tb_top.sv */
// Self-checking testbench for the timer clock select and prescaler block
`timescale 1ns/1ps
module timer_clock_select_prescaler_tb_top;
    import timer_clk_pkg::*;

    // Clock rate table row: settings, then count gained per timer over WIN cycles
    typedef struct packed {
        logic [7:0] ctrl;
        logic [3:0] split;
        logic [3:0] xsel;
        logic [3:0] bsel;
        logic [NUM_TIMERS-1:0][CNT_W-1:0] gain;
    } rate_row_t;

    // Window is a multiple of 12, 48 and 64 so every periodic enable counts exactly
    localparam int WIN = 192;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [SFR_ADDR_W-1:0] sfr_addr = '0;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [SFR_DATA_W-1:0] sfr_wdata = '0;
    logic [SFR_DATA_W-1:0] sfr_rdata;
    logic pin_zero = 1'b1;
    logic pin_one = 1'b1;
    logic ext_osc_clk = 1'b0;
    logic [1:0] osc_div = 2'h0;
    logic cnt_sel_zero = 1'b0;
    logic cnt_sel_one = 1'b0;
    logic [1:0] mode_zero = MODE_16BIT;
    logic [1:0] mode_one = MODE_16BIT;
    logic [NUM_ARL-1:0] split_mode = '0;
    logic [3:0] xsel = 4'h0;
    logic [3:0] bsel = 4'h0;
    logic [NUM_ARL-1:0][CNT_W-1:0] reload_value = '0;
    logic [NUM_TIMERS-1:0] timer_run = '0;
    logic [NUM_TIMERS-1:0] timer_load = '0;
    logic [CNT_W-1:0] load_value = '0;
    logic [NUM_TIMERS-1:0][CNT_W-1:0] count_value;
    logic [NUM_TIMERS-1:0] overflow_low;
    logic [NUM_TIMERS-1:0] overflow_high;
    int n_mismatch = 0;
    int compares = 0;

    timer_clock_select_prescaler dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .timer_zero_count_input(pin_zero), .timer_one_count_input(pin_one),
        .ext_osc_clk(ext_osc_clk), .timer_zero_counter_sel(cnt_sel_zero),
        .timer_one_counter_sel(cnt_sel_one), .timer_zero_mode(mode_zero),
        .timer_one_mode(mode_one), .split_mode(split_mode),
        .timer_two_ext_clock_sel(xsel[0]), .timer_three_ext_clock_sel(xsel[1]),
        .timer_four_ext_clock_sel(xsel[2]), .timer_five_ext_clock_sel(xsel[3]),
        .timer_four_five_byte_clock_sel(bsel), .reload_value(reload_value),
        .timer_run(timer_run), .timer_load(timer_load), .load_value(load_value),
        .count_value(count_value), .overflow_low(overflow_low), .overflow_high(overflow_high)
    );

    // System clock, 10 ns period
    always #5 clk_sys = ~clk_sys;

    // External oscillator at an eighth of the system clock, well under the quarter limit
    always @(posedge clk_sys) begin
        osc_div <= osc_div + 2'h1;
        if (osc_div == 2'h3) begin
            ext_osc_clk <= ~ext_osc_clk;
        end
    end

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask

    // Read data is registered, so it is sampled just after the edge that takes the strobe
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask

    task automatic load_timers(input logic [5:0] which, input logic [15:0] v);
        @(posedge clk_sys);
        timer_load <= which;
        load_value <= v;
        @(posedge clk_sys);
        timer_load <= '0;
    endtask

    task automatic end_of_test;
        $display("compares %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        logic [7:0] rd;
        logic got;
        logic [NUM_TIMERS-1:0][CNT_W-1:0] c0;
        rate_row_t rows [5];
        logic [15:0] wl [4];
        logic [15:0] we [4];
        logic [2:0][15:0] sp0;
        logic [2:0][15:0] sp4;
        logic [2:0][15:0] sp5;
        logic [2:0][5:0] spl;
        logic [2:0][5:0] sph;
        rows[0] = '{8'ha0, 4'h0, 4'h0, 4'h0, {6{16'h0010}}};
        rows[1] = '{8'h09, 4'h0, 4'h5, 4'h4,
            {16'h00c0, 16'h0003, 16'h0010, 16'h0003, 16'h00c0, 16'h0030}};
        rows[2] = '{8'h46, 4'h0, 4'h0, 4'h1,
            {16'h0010, 16'h00c0, 16'h00c0, 16'h0010, 16'h0004, 16'h00c0}};
        rows[3] = '{8'h63, 4'h3, 4'ha, 4'h0,
            {16'h0003, 16'h0010, 16'h03c0, 16'hc010, 16'h0003, 16'h0003}};
        rows[4] = '{8'h90, 4'h3, 4'h0, 4'h0,
            {16'h0010, 16'h0010, 16'hc010, 16'h10c0, 16'h0010, 16'h0010}};
        wl = '{16'hff1e, 16'h40fe, 16'hfffe, 16'hfffe};
        we = '{16'h0000, 16'h4040, 16'h1234, 16'h5a5a};
        // Split test expectations, first step in the lowest slot
        sp0 = {16'h0001, 16'hff00, 16'hfeff};
        sp4 = {16'ha55b, 16'hff5a, 16'hfeff};
        sp5 = {16'h1235, 16'hff34, 16'hfeff};
        spl = {6'h00, 6'h31, 6'h00};
        sph = {6'h31, 6'h00, 6'h00};
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;

        // Control register: reset value, read back, one-cycle read data, unmapped address
        reg_read(CLK_CTRL_ADDR, rd);
        chk_reg(rd, 8'h00, "reset value");
        reg_write(CLK_CTRL_ADDR, 8'ha5);
        reg_read(CLK_CTRL_ADDR, rd);
        chk_reg(rd, 8'ha5, "read back");
        @(posedge clk_sys);
        #1 chk_reg(sfr_rdata, 8'h00, "read data after its cycle");
        reg_write(8'h8f, 8'h3c);
        reg_read(8'h8f, rd);
        chk_reg(rd, 8'h00, "unmapped read");
        reg_read(CLK_CTRL_ADDR, rd);
        chk_reg(rd, 8'ha5, "unmapped write ignored");
        $display("test registers done");

        // Clock rates of all six timers under every prescale code and select bit
        timer_run <= '1;
        for (int r = 0; r < 5; r++) begin
            reg_write(CLK_CTRL_ADDR, rows[r].ctrl);
            split_mode <= rows[r].split;
            xsel <= rows[r].xsel;
            bsel <= rows[r].bsel;
            load_timers(6'h3f, 16'h0000);
            // Short settle keeps every byte clear of a wrap inside the window
            repeat (40) @(posedge clk_sys);
            #1 c0 = count_value;
            repeat (WIN) @(posedge clk_sys);
            #1;
            for (int i = 0; i < NUM_TIMERS; i++) begin
                chk_cnt(count_value[i] - c0[i], rows[r].gain[i], "gain");
            end
        end
        $display("test clock rates done");

        // Event counting at the fastest legal rate; select bits set but must be ignored
        reg_write(CLK_CTRL_ADDR, 8'h0c);
        cnt_sel_zero <= 1'b1;
        cnt_sel_one <= 1'b1;
        repeat (20) @(posedge clk_sys);
        #1 c0 = count_value;
        repeat (20) @(posedge clk_sys);
        #1 chk_cnt(count_value[0] - c0[0], 16'h0000, "idle pin zero");
        chk_cnt(count_value[1] - c0[1], 16'h0000, "idle pin one");
        for (int k = 0; k < 10; k++) begin
            @(posedge clk_sys);
            pin_zero <= 1'b0;
            pin_one <= 1'b0;
            @(posedge clk_sys);
            @(posedge clk_sys);
            pin_zero <= 1'b1;
            pin_one <= 1'b1;
            @(posedge clk_sys);
        end
        repeat (6) @(posedge clk_sys);
        #1 chk_cnt(count_value[0] - c0[0], 16'h000a, "events zero");
        chk_cnt(count_value[1] - c0[1], 16'h000a, "events one");
        $display("test event counting done");

        // Wrap and reload in 13-bit, 8-bit reload and 16-bit reload modes; timers 0 to 3 all on the system clock through their select bits
        @(posedge clk_sys);
        cnt_sel_zero <= 1'b0;
        cnt_sel_one <= 1'b0;
        timer_run <= '0;
        mode_zero <= MODE_13BIT;
        mode_one <= MODE_8RELOAD;
        split_mode <= '0;
        reload_value <= {16'h0000, 16'h0000, 16'h5a5a, 16'h1234};
        reg_write(CLK_CTRL_ADDR, 8'h5c);
        for (int i = 0; i < 4; i++) begin
            load_timers(6'h01 << i, wl[i]);
            timer_run <= 6'h01 << i;
            got = 1'b0;
            for (int c = 0; c < 20 && !got; c++) begin
                @(posedge clk_sys);
                #1 got = (overflow_high[i] === 1'b1);
            end
            chk_flag(got, 1'b1, "overflow pulse");
            chk_cnt(count_value[i], we[i], "value after wrap");
            @(posedge clk_sys);
            timer_run <= '0;
        end
        $display("test wrap and reload done");

        // Split modes on the system clock: bytes wrap one step apart so each flag stands alone
        mode_zero <= MODE_SPLIT;
        mode_one <= MODE_SPLIT;
        split_mode <= 4'hc;
        bsel <= 4'hf;
        reload_value <= {16'h1234, 16'ha55a, 16'h0000, 16'h0000};
        load_timers(6'h33, 16'hfdfe);
        timer_run <= 6'h33;
        for (int s = 0; s < 3; s++) begin
            @(posedge clk_sys);
            #1 chk_cnt(count_value[0], sp0[s], "split timer 0");
            chk_cnt(count_value[1], 16'hfdfe, "timer 1 held in split");
            chk_cnt(count_value[4], sp4[s], "split timer 4");
            chk_cnt(count_value[5], sp5[s], "split timer 5");
            for (int i = 0; i < NUM_TIMERS; i++) begin
                chk_flag(overflow_low[i], spl[s][i], "low byte overflow");
                chk_flag(overflow_high[i], sph[s][i], "high byte overflow");
            end
        end
        $display("test split modes done");
        end_of_test();
    end
endmodule
